// file: src/tae_regs.svh
`ifndef TAE_REGS_SVH
`define TAE_REGS_SVH

// general register that serves as stack pointer
`define TAE_SP_IDX 3'h7
// pointer step per operand size
`define TAE_STEP_BYTE 16'h0001
`define TAE_STEP_WORD 16'h0002
// upper address byte of the short absolute form
`define TAE_ABS8_PAGE 8'hFF
// mask that clears the low address bit of word accesses
`define TAE_WORD_ALIGN 16'hFFFE
// general register reset value
`define TAE_GPR_RST 16'h0000
// legal implied constants of the word small-constant forms
`define TAE_SMALL_ONE 16'h0001
`define TAE_SMALL_TWO 16'h0002

`endif

// file: src/tae_pkg.sv
package tae_pkg;

    typedef enum logic [3:0] {
        data_move_op              = 4'h0,
        stack_push_op             = 4'h1,
        stack_pop_op              = 4'h2,
        periph_sync_store_op      = 4'h3,
        periph_sync_load_op       = 4'h4,
        sum_op                    = 4'h5,
        difference_op             = 4'h6,
        sum_with_carry_op         = 4'h7,
        difference_with_borrow_op = 4'h8,
        plus_one_op               = 4'h9,
        minus_one_op              = 4'hA,
        word_plus_small_op        = 4'hB,
        word_minus_small_op       = 4'hC
    } tae_op_e;

    typedef enum logic [2:0] {
        mode_reg   = 3'h0,
        mode_ind   = 3'h1,
        mode_disp  = 3'h2,
        mode_abs16 = 3'h3,
        mode_abs8  = 3'h4,
        mode_imm   = 3'h5,
        mode_pre   = 3'h6,
        mode_post  = 3'h7
    } tae_mode_e;

    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_mem  = 2'h1
    } tae_state_e;

endpackage : tae_pkg

// file: src/tae_addsub.sv
`timescale 1ns/10ps
`default_nettype none

module tae_addsub
(
    // operands
    input wire logic [15:0] opa,
    input wire logic [15:0] opb,
    input wire logic cin,
    input wire logic sub,
    // result
    output logic [15:0] sum
);

    // byte operands arrive zero-extended; only the low byte is used then
    always_comb
    begin
        if (sub)
            sum = opa - opb - {15'h0000, cin};
        else
            sum = opa + opb + {15'h0000, cin};
    end

endmodule : tae_addsub

`default_nettype wire

// file: src/tae_exec.sv
`timescale 1ns/10ps
`default_nettype none
`include "tae_regs.svh"

// How it works
// - move copies byte or word between registers, memory and immediate, all listed modes except word short absolute and byte auto-step on the stack pointer
// - short absolute form is taken only for byte moves
// - push is a word move to memory with stack pointer pre-decrement
// - pop is a word load from stack pointer address with post-increment
// - both peripheral-synchronised transfer opcodes are not implemented
// - add and subtract work register to register; add also takes immediate
// - there is no subtract with immediate source
// - word add or subtract only with both operands in registers
// - add-with-carry and subtract-with-borrow are byte only, using carry input
// - increment and decrement change a byte register by one
// - word small-constant add and subtract accept only one or two
// - pre-decrement before access, post-increment after, step one or two
// - word accesses clear the low address bit
module tae_exec
    import tae_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // instruction stream
    input wire logic instr_valid,
    input wire tae_op_e instr_op,
    input wire logic instr_word,
    input wire tae_mode_e instr_mode,
    input wire logic instr_store,
    input wire logic [3:0] instr_reg_a,
    input wire logic [3:0] instr_reg_b,
    input wire logic [15:0] instr_ext,
    input wire logic carry_in,
    output logic instr_ready,
    output logic done,
    output logic illegal,
    // memory bus
    output logic mem_req,
    output logic mem_we,
    output logic mem_word,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // register inspection
    input wire logic [2:0] peek_sel,
    output logic [15:0] peek_data
);

    logic [15:0] gpr_r [0:7];
    logic [15:0] gpr_nxt [0:7];
    tae_state_e state_r, state_nxt;
    logic ready_r, ready_nxt, done_r, done_nxt, illegal_r, illegal_nxt;
    logic req_r, req_nxt, we_r, we_nxt, word_r, word_nxt, post_r, post_nxt;
    logic [15:0] addr_r, addr_nxt, wdata_r, wdata_nxt, peek_r, peek_nxt;
    logic [3:0] dreg_r, dreg_nxt;
    logic [2:0] ptr_r, ptr_nxt;

    logic accept, legal, is_mem, eff_word, eff_store, alu_sub, alu_cin;
    tae_mode_e eff_mode;
    logic [2:0] eff_ptr;
    logic [15:0] a_word, b_word, alu_a, alu_b, alu_y, res, ptr_val, step, ea;

    function automatic logic [7:0] byte_of(input logic [15:0] w, input logic low);
        byte_of = low ? w[7:0] : w[15:8];
    endfunction : byte_of

    function automatic logic [15:0] put_byte(input logic [15:0] w, input logic low,
                                             input logic [7:0] b);
        put_byte = low ? {w[15:8], b} : {b, w[7:0]};
    endfunction : put_byte

    tae_addsub u_addsub
    (
        .opa(alu_a),
        .opb(alu_b),
        .cin(alu_cin),
        .sub(alu_sub),
        .sum(alu_y)
    );

    // decode: effective operand shape, legality, result and address
    always_comb
    begin
        accept = instr_valid && ready_r;
        a_word = gpr_r[instr_reg_a[2:0]];
        b_word = gpr_r[instr_reg_b[2:0]];
        eff_mode = instr_mode;
        eff_word = instr_word;
        eff_store = instr_store;
        eff_ptr = instr_reg_b[2:0];
        if (instr_op == stack_push_op)
        begin
            eff_mode = mode_pre;
            eff_word = 1'h1;
            eff_store = 1'h1;
            eff_ptr = `TAE_SP_IDX;
        end
        else if (instr_op == stack_pop_op)
        begin
            eff_mode = mode_post;
            eff_word = 1'h1;
            eff_store = 1'h0;
            eff_ptr = `TAE_SP_IDX;
        end
        else if (instr_op == word_plus_small_op || instr_op == word_minus_small_op)
            eff_mode = mode_reg;
        is_mem = !(eff_mode == mode_reg || eff_mode == mode_imm);
        step = eff_word ? `TAE_STEP_WORD : `TAE_STEP_BYTE;
        alu_a = eff_word ? a_word : {8'h00, byte_of(a_word, instr_reg_a[3])};
        if (eff_mode == mode_imm)
            alu_b = eff_word ? instr_ext : {8'h00, instr_ext[7:0]};
        else
            alu_b = eff_word ? b_word : {8'h00, byte_of(b_word, instr_reg_b[3])};
        alu_sub = 1'h0;
        alu_cin = 1'h0;
        legal = 1'h1;
        case (instr_op)
            data_move_op, stack_push_op, stack_pop_op:
            begin
                if (eff_mode == mode_abs8 && eff_word)
                    legal = 1'h0;
                if ((eff_mode == mode_pre || eff_mode == mode_post) && !eff_word
                    && eff_ptr == `TAE_SP_IDX)
                    legal = 1'h0;
                if (!is_mem && eff_store)
                    legal = 1'h0;
            end
            sum_op, difference_op:
            begin
                alu_sub = (instr_op == difference_op);
                if (is_mem)
                    legal = 1'h0;
                if (eff_mode == mode_imm && alu_sub)
                    legal = 1'h0;
                if (eff_mode == mode_imm && eff_word)
                    legal = 1'h0;
            end
            sum_with_carry_op, difference_with_borrow_op:
            begin
                alu_sub = (instr_op == difference_with_borrow_op);
                alu_cin = carry_in;
                if (is_mem || eff_word)
                    legal = 1'h0;
            end
            plus_one_op, minus_one_op:
            begin
                alu_sub = (instr_op == minus_one_op);
                alu_b = `TAE_STEP_BYTE;
                if (eff_mode != mode_reg || eff_word)
                    legal = 1'h0;
            end
            word_plus_small_op, word_minus_small_op:
            begin
                alu_sub = (instr_op == word_minus_small_op);
                alu_a = a_word;
                alu_b = instr_ext;
                if (!eff_word || (instr_ext != `TAE_SMALL_ONE && instr_ext != `TAE_SMALL_TWO))
                    legal = 1'h0;
            end
            default:
                legal = 1'h0;
        endcase
        // moves copy the source; everything else takes the adder result
        if (instr_op == data_move_op)
            res = alu_b;
        else
            res = alu_y;
        ptr_val = gpr_r[eff_ptr];
        case (eff_mode)
            mode_disp: ea = ptr_val + instr_ext;
            mode_abs16: ea = instr_ext;
            mode_abs8: ea = {`TAE_ABS8_PAGE, instr_ext[7:0]};
            mode_pre: ea = ptr_val - step;
            default: ea = ptr_val;
        endcase
    end

    // next state of the sequencer and the register file
    always_comb
    begin
        gpr_nxt = gpr_r;
        state_nxt = state_r;
        ready_nxt = ready_r;
        done_nxt = 1'h0;
        illegal_nxt = 1'h0;
        req_nxt = req_r;
        we_nxt = we_r;
        word_nxt = word_r;
        post_nxt = post_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        dreg_nxt = dreg_r;
        ptr_nxt = ptr_r;
        peek_nxt = gpr_r[peek_sel];
        case (state_r)
            st_idle:
            begin
                if (accept && !legal)
                    illegal_nxt = 1'h1;
                else if (accept && is_mem)
                begin
                    if (eff_mode == mode_pre)
                        gpr_nxt[eff_ptr] = ea;
                    req_nxt = 1'h1;
                    we_nxt = eff_store;
                    word_nxt = eff_word;
                    addr_nxt = eff_word ? (ea & `TAE_WORD_ALIGN) : ea;
                    wdata_nxt = eff_word ? a_word : {8'h00, byte_of(a_word, instr_reg_a[3])};
                    dreg_nxt = instr_reg_a;
                    ptr_nxt = eff_ptr;
                    post_nxt = (eff_mode == mode_post);
                    ready_nxt = 1'h0;
                    state_nxt = st_mem;
                end
                else if (accept)
                begin
                    // register forms finish in the accepting cycle
                    if (eff_word)
                        gpr_nxt[instr_reg_a[2:0]] = res;
                    else
                        gpr_nxt[instr_reg_a[2:0]] = put_byte(a_word, instr_reg_a[3], res[7:0]);
                    done_nxt = 1'h1;
                end
            end
            st_mem:
            begin
                if (mem_ack)
                begin
                    if (post_r)
                        gpr_nxt[ptr_r] = gpr_r[ptr_r] + (word_r ? `TAE_STEP_WORD
                                                                 : `TAE_STEP_BYTE);
                    // a word load into the pointer itself wins over the increment; a byte load replaces only one byte of it
                    if (!we_r && word_r)
                        gpr_nxt[dreg_r[2:0]] = mem_rdata;
                    else if (!we_r)
                        gpr_nxt[dreg_r[2:0]] = put_byte(gpr_nxt[dreg_r[2:0]], dreg_r[3],
                                                        mem_rdata[7:0]);
                    req_nxt = 1'h0;
                    ready_nxt = 1'h1;
                    done_nxt = 1'h1;
                    state_nxt = st_idle;
                end
            end
            default:
            begin
                req_nxt = 1'h0;
                ready_nxt = 1'h1;
                state_nxt = st_idle;
            end
        endcase
        // ready comes up by itself once reset is gone and nothing is pending
        if (state_r == st_idle && state_nxt == st_idle)
            ready_nxt = 1'h1;
    end

    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_gpr
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                    gpr_r[i] <= `TAE_GPR_RST;
                else
                    gpr_r[i] <= gpr_nxt[i];
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= st_idle;
            ready_r <= 1'h0;
            done_r <= 1'h0;
            illegal_r <= 1'h0;
            req_r <= 1'h0;
            we_r <= 1'h0;
            word_r <= 1'h0;
            post_r <= 1'h0;
            addr_r <= 16'h0000;
            wdata_r <= 16'h0000;
            dreg_r <= 4'h0;
            ptr_r <= 3'h0;
            peek_r <= 16'h0000;
        end
        else
        begin
            state_r <= state_nxt;
            ready_r <= ready_nxt;
            done_r <= done_nxt;
            illegal_r <= illegal_nxt;
            req_r <= req_nxt;
            we_r <= we_nxt;
            word_r <= word_nxt;
            post_r <= post_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            dreg_r <= dreg_nxt;
            ptr_r <= ptr_nxt;
            peek_r <= peek_nxt;
        end
    end

    assign instr_ready = ready_r;
    assign done = done_r;
    assign illegal = illegal_r;
    assign mem_req = req_r;
    assign mem_we = we_r;
    assign mem_word = word_r;
    assign mem_addr = addr_r;
    assign mem_wdata = wdata_r;
    assign peek_data = peek_r;

    // checks
    logic [15:0] sp_w, ptr_cur;
    assign sp_w = gpr_r[`TAE_SP_IDX];
    assign ptr_cur = gpr_r[ptr_r];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sequence s_push_taken;
        accept && instr_op == stack_push_op;
    endsequence
    sequence s_pop_taken;
        accept && instr_op == stack_pop_op;
    endsequence
    sequence s_post_done;
        state_r == st_mem && mem_ack && post_r && !(!we_r && dreg_r[2:0] == ptr_r);
    endsequence

    AST_ABS8_WORD: assert property (accept && instr_op == data_move_op
        && instr_mode == mode_abs8 && instr_word |=> illegal_r && !req_r)
        else $error("word move with short absolute was not rejected");
    AST_SP_BYTE: assert property (accept && instr_op == data_move_op && !instr_word
        && (instr_mode == mode_pre || instr_mode == mode_post)
        && instr_reg_b[2:0] == `TAE_SP_IDX |=> illegal_r)
        else $error("byte stack pointer auto-step was not rejected");
    AST_PUSH: assert property (s_push_taken |=> req_r && we_r && word_r
        && sp_w == $past(sp_w) - `TAE_STEP_WORD
        && addr_r == (($past(sp_w) - `TAE_STEP_WORD) & `TAE_WORD_ALIGN))
        else $error("push did not pre-decrement the stack pointer");
    AST_POP: assert property (s_pop_taken |=> req_r && !we_r && word_r
        && sp_w == $past(sp_w) && addr_r == ($past(sp_w) & `TAE_WORD_ALIGN))
        else $error("pop did not address the stack pointer");
    AST_PERIPH: assert property (accept && (instr_op == periph_sync_store_op
        || instr_op == periph_sync_load_op) |=> illegal_r && !done_r && !req_r)
        else $error("peripheral transfer was executed");
    AST_SUB_IMM: assert property (accept && instr_op == difference_op
        && instr_mode == mode_imm |=> illegal_r)
        else $error("subtract with immediate was accepted");
    AST_WORD_IMM_ADD: assert property (accept && instr_op == sum_op && instr_word
        && instr_mode != mode_reg |=> illegal_r)
        else $error("word add without two registers was accepted");
    AST_CARRY_WORD: assert property (accept && instr_word
        && (instr_op == sum_with_carry_op || instr_op == difference_with_borrow_op)
        |=> illegal_r)
        else $error("word carry arithmetic was accepted");
    AST_SMALL_CONST: assert property (accept && (instr_op == word_plus_small_op
        || instr_op == word_minus_small_op) && instr_ext != `TAE_SMALL_ONE
        && instr_ext != `TAE_SMALL_TWO |=> illegal_r)
        else $error("small constant outside one or two was accepted");
    AST_POST_STEP: assert property (s_post_done |=>
        ptr_cur == $past(ptr_cur) + ($past(word_r) ? `TAE_STEP_WORD : `TAE_STEP_BYTE))
        else $error("post-increment step is wrong");
    AST_WORD_EVEN: assert property (req_r && word_r |-> !addr_r[0])
        else $error("word access on odd address");
    AST_REG_DONE: assert property (accept && legal && !is_mem
        |=> done_r && !req_r && ready_r)
        else $error("register operation did not finish in one cycle");
    AST_MEM_HOLD: assert property (req_r && !mem_ack
        |=> req_r && $stable(addr_r) && $stable(we_r) && $stable(wdata_r))
        else $error("memory request changed before acknowledge");
    AST_UNDEF: assert property (accept && !legal
        |=> illegal_r && !done_r && !req_r ##1 (!illegal_r || $past(accept && !legal)))
        else $error("undefined opcode not flagged as one pulse");

endmodule : tae_exec

`default_nettype wire

// file: test/tae_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module tae_mem_model
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // request from the block
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_word,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    // answer after lat waiting cycles
    input wire logic [1:0] lat,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_r;
    logic [15:0] last_addr;
    logic [15:0] last_wdata;
    logic last_we;
    logic last_word;
    int acc_n;
    // read data toggles outside ack, so a stale value never passes for a fresh one
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            mem_ack <= 1'b0;
            wait_r <= 2'h0;
            mem_rdata <= 16'h0000;
            acc_n <= 0;
        end
        else if (mem_ack || !mem_req || wait_r != lat)
        begin
            mem_ack <= 1'b0;
            wait_r <= (mem_req && !mem_ack) ? wait_r + 2'h1 : 2'h0;
            mem_rdata <= ~mem_rdata;
        end
        else
        begin
            mem_ack <= 1'b1;
            wait_r <= 2'h0;
            acc_n <= acc_n + 1;
            last_addr <= mem_addr;
            last_we <= mem_we;
            last_word <= mem_word;
            last_wdata <= mem_wdata;
            // high byte first in memory; byte reads carry junk above bit 7
            mem_rdata <= {mem_word ? mem[mem_addr] : 8'hA5, mem[mem_addr | {15'h0000, mem_word}]};
            if (mem_we)
            begin
                mem[mem_addr | {15'h0000, mem_word}] <= mem_wdata[7:0];
                if (mem_word)
                    mem[mem_addr] <= mem_wdata[15:8];
            end
        end
    end
endmodule : tae_mem_model
`default_nettype wire

// file: test/transfer_arith_exec_tb.sv
`timescale 1ns/10ps
`default_nettype none
module transfer_arith_exec_tb
    import tae_pkg::*;
;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic instr_valid = 1'b0;
    tae_op_e instr_op = data_move_op;
    logic instr_word = 1'b0;
    tae_mode_e instr_mode = mode_reg;
    logic instr_store = 1'b0;
    logic [3:0] instr_reg_a = 4'h0;
    logic [3:0] instr_reg_b = 4'h0;
    logic [15:0] instr_ext = 16'h0000;
    logic carry_in = 1'b0;
    logic [2:0] peek_sel = 3'h0;
    logic [1:0] lat = 2'h0;
    logic instr_ready, done, illegal, mem_req, mem_we, mem_word, mem_ack;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, peek_data;
    logic [15:0] g [0:7];
    logic [15:0] ill [0:15] = '{16'h3000, 16'h4000, 16'hD000, 16'hE000, 16'hF000, 16'h6500,
        16'h5D00, 16'h7800, 16'h8800, 16'hB803, 16'hC800, 16'h9800, 16'h0C00, 16'h06F0,
        16'h0770, 16'h0080};
    logic cy = 1'b0;
    int seed = 50417;
    int mismatches = 0;
    int compares = 0;
    int cyc = 0;

    always #25 mclk = ~mclk;

    tae_exec tae_exec_i
    (
        .mclk(mclk), .nrst(nrst), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_word(instr_word), .instr_mode(instr_mode), .instr_store(instr_store),
        .instr_reg_a(instr_reg_a), .instr_reg_b(instr_reg_b), .instr_ext(instr_ext),
        .carry_in(carry_in), .instr_ready(instr_ready), .done(done), .illegal(illegal),
        .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .peek_sel(peek_sel), .peek_data(peek_data)
    );

    tae_mem_model tae_mem_model_i
    (
        .mclk(mclk), .nrst(nrst), .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata)
    );

    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // offers one instruction, waits for its outcome and checks done and illegal against ok
    task automatic ins(input logic [3:0] op, input logic w, input logic [2:0] md, input logic st,
                       input logic [3:0] a, input logic [3:0] b, input logic [15:0] ext,
                       input logic ok);
        int n;
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr_op <= tae_op_e'(op);
        instr_word <= w;
        instr_mode <= tae_mode_e'(md);
        instr_store <= st;
        instr_reg_a <= a;
        instr_reg_b <= b;
        instr_ext <= ext;
        carry_in <= cy;
        lat <= 2'($random(seed));
        @(negedge mclk);
        while (instr_ready !== 1'b1)
            @(negedge mclk);
        @(posedge mclk);
        instr_valid <= 1'b0;
        @(negedge mclk);
        for (n = 0; n < 40 && done !== 1'b1 && illegal !== 1'b1; n++)
            @(negedge mclk);
        chk("done", 16'(ok), 16'(done));
        chk("illegal", 16'(!ok), 16'(illegal));
    endtask : ins

    task automatic reg_is(input logic [2:0] r);
        @(posedge mclk);
        peek_sel <= r;
        @(posedge mclk);
        @(negedge mclk);
        chk("gpr", g[r], peek_data);
    endtask : reg_is

    task automatic acc_is(input logic we, input logic w, input logic [15:0] ad,
                          input logic [15:0] wd);
        chk("mem_we", 16'(we), 16'(tae_mem_model_i.last_we));
        chk("mem_word", 16'(w), 16'(tae_mem_model_i.last_word));
        chk("mem_addr", ad, tae_mem_model_i.last_addr);
        if (we)
            chk("mem_wdata", wd, tae_mem_model_i.last_wdata);
    endtask : acc_is

    function automatic logic [7:0] bget(input logic [3:0] r);
        return r[3] ? g[r[2:0]][7:0] : g[r[2:0]][15:8];
    endfunction : bget

    task automatic bput(input logic [3:0] r, input logic [7:0] v);
        if (r[3])
            g[r[2:0]][7:0] = v;
        else
            g[r[2:0]][15:8] = v;
    endtask : bput

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            end_sim();
        end
    end

    initial
    begin : main
        int k;
        int n0;
        logic [3:0] a, b, op;
        logic [15:0] x, d, s, r;
        repeat (5) @(posedge mclk);
        chk("ready in reset", 16'h0000, 16'({instr_ready, mem_req, done}));
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        for (k = 0; k < 8; k++)
        begin
            g[k] = (k == 7) ? 16'h0400 : 16'($random(seed));
            ins(4'h0, 1'b1, 3'h5, 1'b0, 4'(k), 4'h0, g[k], 1'b1);
            reg_is(3'(k));
        end
        $display("test load finished");
        // kinds: add/sub word, sub byte, add imm, carry forms, inc, dec, small, moves
        for (n0 = 0; n0 < 60; n0++)
        begin
            k = $unsigned($random(seed)) % 12;
            x = 16'($random(seed));
            a = {x[15], 3'($unsigned($random(seed)) % 7)};
            b = 4'($random(seed));
            cy = x[13];
            op = 4'(48'h00CBA9875665 >> (k * 4));
            if (op == 4'hB || op == 4'hC)
                x = x[0] ? 16'h0002 : 16'h0001;
            s = (12'h828 >> k) & 1 || op > 4'hA ? x : 12'h703 >> k & 1 ? g[b[2:0]] : 16'(bget(b));
            d = 12'h703 >> k & 1 ? g[a[2:0]] : 16'(bget(a));
            case (op)
                4'h5, 4'h7, 4'hB: r = d + s + 16'(op == 4'h7 && cy);
                4'h6, 4'h8, 4'hC: r = d - s - 16'(op == 4'h8 && cy);
                4'h9: r = d + 16'h0001;
                4'hA: r = d - 16'h0001;
                default: r = s;
            endcase
            ins(op, 1'(12'h703 >> k), 3'h5 * 3'(12'h828 >> k & 1), 1'b0, a, b, x, 1'b1);
            if (12'h703 >> k & 1)
                g[a[2:0]] = r;
            else
                bput(a, r[7:0]);
            reg_is(a[2:0]);
        end
        $display("test arith finished");
        n0 = tae_mem_model_i.acc_n;
        for (k = 0; k < 16; k++)
        begin
            x = ill[k];
            ins(x[15:12], x[11], x[10:8], x[7], 4'h0, {1'b0, x[6:4]}, 16'(x[3:0]), 1'b0);
        end
        chk("accesses", 16'(n0), 16'(tae_mem_model_i.acc_n));
        reg_is(3'h0);
        reg_is(3'h7);
        $display("test undefined finished");
        // stack traffic keeps word size on the stack pointer
        for (k = 1; k < 5; k++)
        begin
            if (k < 3)
                g[7] = g[7] - 16'h0002;
            ins(k < 3 ? 4'h1 : 4'h2, 1'b0, 3'h0, 1'b0, 4'(k), 4'h0, 16'h0000, 1'b1);
            acc_is(k < 3, 1'b1, g[7], g[k]);
            if (k > 2)
            begin
                g[k] = g[5 - k];
                g[7] = g[7] + 16'h0002;
            end
            reg_is(3'(k));
            reg_is(3'h7);
        end
        g[5] = 16'h2001;
        ins(4'h0, 1'b1, 3'h5, 1'b0, 4'h5, 4'h0, g[5], 1'b1);
        ins(4'h0, 1'b0, 3'h6, 1'b1, 4'h8, 4'h5, 16'h0000, 1'b1);
        g[5] = 16'h2000;
        acc_is(1'b1, 1'b0, 16'h2000, 16'(g[0][7:0]));
        reg_is(3'h5);
        ins(4'h0, 1'b0, 3'h7, 1'b0, 4'h6, 4'h5, 16'h0000, 1'b1);
        bput(4'h6, g[0][7:0]);
        g[5] = 16'h2001;
        acc_is(1'b0, 1'b0, 16'h2000, 16'h0000);
        reg_is(3'h5);
        reg_is(3'h6);
        ins(4'h0, 1'b1, 3'h3, 1'b1, 4'h3, 4'h0, 16'h3001, 1'b1);
        acc_is(1'b1, 1'b1, 16'h3000, g[3]);
        g[0] = 16'h2FF0;
        ins(4'h0, 1'b1, 3'h5, 1'b0, 4'h0, 4'h0, g[0], 1'b1);
        ins(4'h0, 1'b1, 3'h2, 1'b0, 4'h4, 4'h0, 16'h0011, 1'b1);
        g[4] = g[3];
        acc_is(1'b0, 1'b1, 16'h3000, 16'h0000);
        reg_is(3'h4);
        ins(4'h0, 1'b1, 3'h1, 1'b1, 4'h2, 4'h0, 16'h0000, 1'b1);
        acc_is(1'b1, 1'b1, 16'h2FF0, g[2]);
        ins(4'h0, 1'b0, 3'h4, 1'b1, 4'hA, 4'h0, 16'h0034, 1'b1);
        acc_is(1'b1, 1'b0, 16'hFF34, 16'(g[2][7:0]));
        ins(4'h0, 1'b0, 3'h3, 1'b0, 4'h1, 4'h0, 16'hFF34, 1'b1);
        bput(4'h1, g[2][7:0]);
        reg_is(3'h1);
        $display("test memory finished");
        end_sim();
    end
endmodule : transfer_arith_exec_tb
`default_nettype wire
